// ==== verilog/cfg_word_pkg.sv ====
// constants and types for the configuration word decoder
package cfg_word_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses on the bus)
  // ---------------------------------------------------------------
  localparam logic [15:0] CFG_WORD_ADDR  = 16'h2007;
  localparam logic [15:0] CTRL_ADDR      = 16'h2010;
  localparam logic [15:0] STATUS_ADDR    = 16'h2014;
  localparam logic [15:0] CFG_WORD_RESET = 16'h0fff;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int BROWNOUT_HI    = 9;
  localparam int BROWNOUT_LO    = 8;
  localparam int RESET_PIN_BIT  = 5;
  localparam int PWRUP_BIT      = 4;
  localparam int OSC_SEL_HI     = 2;
  localparam int OSC_SEL_LO     = 0;
  localparam int IMPL_HI        = 11;
  localparam int CTRL_SW_BOR    = 0;
  localparam int CTRL_SLEEP     = 1;
  localparam int CTRL_PIN_RESET = 2;
  localparam logic [31:0] CTRL_MASK = 32'h0000_0007;

  // ---------------------------------------------------------------
  // brown-out modes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    BOR_OFF      = 2'b00,
    BOR_SOFTWARE = 2'b01,
    BOR_AWAKE    = 2'b10,
    BOR_ON       = 2'b11
  } brownout_mode_e;

  // oscillator codes that run the on-chip oscillator
  localparam logic [2:0] OSC_INT_NOCLK = 3'h4;
  localparam logic [2:0] OSC_INT_CLK   = 3'h5;
  localparam logic [2:0] OSC_RC_NOCLK  = 3'h6;
  localparam logic [2:0] OSC_RC_CLK    = 3'h7;

  // decoded settings
  typedef struct packed {
    logic brownout_reset_en;
    logic powerup_timer_en;
    logic internal_reset;
    logic osc_stop;
    logic chip_reset_req;
  } cfg_ctrl_s;

endpackage

// ==== verilog/config_word_decode.sv ====
// configuration word decoder with a classic wishbone register slave
`timescale 1ns/1ps
module config_word_decode
(
  // clock and reset
  input  wire logic                    mclk,
  input  wire logic                    rst_n,
  // wishbone slave
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [15:0]             wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output logic      [31:0]             wb_dat_o,
  output logic                         wb_ack_o,
  // device pins and state
  input  wire logic                    external_reset_pin_n,
  input  wire logic                    sleep_i,
  // decoded settings
  output cfg_word_pkg::cfg_ctrl_s      cfg_ctrl_o
);

  // ---------------------------------------------------------------
  // pin synchroniser
  // ---------------------------------------------------------------
  logic pin_meta_ff;
  logic pin_sync_ff;
  logic nxt_pin_meta;
  logic nxt_pin_sync;

  // only the second flop feeds the decode; the first may still be settling
  always_comb
  begin
    nxt_pin_meta = external_reset_pin_n;
    nxt_pin_sync = pin_meta_ff;
  end

  // reset to the released level so no false pin event follows reset
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      pin_meta_ff <= 1'b1;
      pin_sync_ff <= 1'b1;
    end
    else
    begin
      pin_meta_ff <= nxt_pin_meta;
      pin_sync_ff <= nxt_pin_sync;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // the word is written by the programmer path; run-time code should only read it
  logic [15:0] cfg_word_ff;
  logic [15:0] nxt_cfg_word;
  logic [2:0]  ctrl_ff;
  logic [2:0]  nxt_ctrl;
  logic        ack_ff;
  logic        nxt_ack;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic        req;
  logic        hit_cfg;
  logic        hit_ctrl;
  logic        hit_stat;

  assign req      = wb_cyc_i && wb_stb_i && !ack_ff;
  assign hit_cfg  = (wb_adr_i == cfg_word_pkg::CFG_WORD_ADDR);
  assign hit_ctrl = (wb_adr_i == cfg_word_pkg::CTRL_ADDR);
  assign hit_stat = (wb_adr_i == cfg_word_pkg::STATUS_ADDR);

  always_comb
  begin
    nxt_cfg_word = cfg_word_ff;
    nxt_ctrl     = ctrl_ff;
    nxt_ack      = req;
    nxt_rdata    = rdata_ff;
    if (req && wb_we_i)
    begin
      if (hit_cfg)
      begin
        if (wb_sel_i[0])
        begin
          nxt_cfg_word[7:0] = wb_dat_i[7:0];
        end
        if (wb_sel_i[1])
        begin
          nxt_cfg_word[15:8] = {4'h0, wb_dat_i[11:8]};
        end
      end
      if (hit_ctrl && wb_sel_i[0])
      begin
        nxt_ctrl = wb_dat_i[2:0];
      end
    end
    else if (req)
    begin
      // unmapped addresses still ack and read zero
      nxt_rdata = 32'h0000_0000;
      if (hit_cfg)
      begin
        nxt_rdata = {16'h0000, 4'h0, cfg_word_ff[cfg_word_pkg::IMPL_HI:0]};
      end
      if (hit_ctrl)
      begin
        nxt_rdata = {29'h0000_0000, ctrl_ff};
      end
      // status shows the registered settings, one cycle behind the word
      if (hit_stat)
      begin
        nxt_rdata = {27'h0000_0000, cfg_ctrl_o};
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      cfg_word_ff <= cfg_word_pkg::CFG_WORD_RESET;
      ctrl_ff     <= 3'h0;
      ack_ff      <= 1'b0;
      rdata_ff    <= 32'h0000_0000;
    end
    else
    begin
      cfg_word_ff <= nxt_cfg_word;
      ctrl_ff     <= nxt_ctrl;
      ack_ff      <= nxt_ack;
      rdata_ff    <= nxt_rdata;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdata_ff;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  cfg_word_pkg::brownout_mode_e bor_mode;
  logic [2:0]                   osc_sel;
  logic                         sw_brownout_enable;
  logic                         sleeping;
  logic                         reset_pin_function;
  logic                         pin_asserted;
  logic                         osc_internal;
  cfg_word_pkg::cfg_ctrl_s      nxt_cfg_ctrl;
  cfg_word_pkg::cfg_ctrl_s      cfg_ctrl_ff;

  assign bor_mode = cfg_word_pkg::brownout_mode_e'(
    cfg_word_ff[cfg_word_pkg::BROWNOUT_HI:cfg_word_pkg::BROWNOUT_LO]);
  assign osc_sel            = cfg_word_ff[cfg_word_pkg::OSC_SEL_HI:cfg_word_pkg::OSC_SEL_LO];
  assign sw_brownout_enable = ctrl_ff[cfg_word_pkg::CTRL_SW_BOR];
  // sleep may come from the core register or the sleep input
  assign sleeping           = ctrl_ff[cfg_word_pkg::CTRL_SLEEP] | sleep_i;
  assign reset_pin_function = cfg_word_ff[cfg_word_pkg::RESET_PIN_BIT];
  assign pin_asserted       = !pin_sync_ff && reset_pin_function;
  assign osc_internal       = (osc_sel == cfg_word_pkg::OSC_INT_NOCLK)
                           || (osc_sel == cfg_word_pkg::OSC_INT_CLK)
                           || (osc_sel == cfg_word_pkg::OSC_RC_NOCLK)
                           || (osc_sel == cfg_word_pkg::OSC_RC_CLK);

  always_comb
  begin
    nxt_cfg_ctrl = '0;
    unique case (bor_mode)
      cfg_word_pkg::BOR_ON:
      begin
        nxt_cfg_ctrl.brownout_reset_en = 1'b1;
      end
      cfg_word_pkg::BOR_OFF:
      begin
        nxt_cfg_ctrl.brownout_reset_en = 1'b0;
      end
      // the software bit is not looked at here, so it cannot keep brown-out on in sleep
      cfg_word_pkg::BOR_AWAKE:
      begin
        nxt_cfg_ctrl.brownout_reset_en = !sleeping;
      end
      cfg_word_pkg::BOR_SOFTWARE:
      begin
        nxt_cfg_ctrl.brownout_reset_en = sw_brownout_enable;
      end
    endcase
    nxt_cfg_ctrl.powerup_timer_en = !cfg_word_ff[cfg_word_pkg::PWRUP_BIT];
    nxt_cfg_ctrl.internal_reset   = !reset_pin_function;
    nxt_cfg_ctrl.osc_stop         = pin_asserted && osc_internal;
    nxt_cfg_ctrl.chip_reset_req   = pin_asserted || ctrl_ff[cfg_word_pkg::CTRL_PIN_RESET];
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      cfg_ctrl_ff <= '0;
    end
    else
    begin
      cfg_ctrl_ff <= nxt_cfg_ctrl;
    end
  end

  assign cfg_ctrl_o = cfg_ctrl_ff;

endmodule

// ==== tb/cfg_programmer.sv ====
// programmer model: the word image burned into configuration memory
`timescale 1ns/1ps
module cfg_programmer
(
  // bits to burn, and the image read back
  input  wire logic [15:0] prog_mask,
  output logic      [31:0] image
);
  assign image = {16'h0000, ~prog_mask};
endmodule

// ==== tb/config_word_decode_properties.sv ====
// assertions on the configuration word decoder ports
`timescale 1ns/1ps
module config_word_decode_properties
(
  // clock, reset, wishbone
  input wire logic                    mclk,
  input wire logic                    rst_n,
  input wire logic                    wb_cyc_i,
  input wire logic                    wb_stb_i,
  input wire logic                    wb_we_i,
  input wire logic [15:0]             wb_adr_i,
  input wire logic [3:0]              wb_sel_i,
  input wire logic [31:0]             wb_dat_i,
  input wire logic [31:0]             wb_dat_o,
  input wire logic                    wb_ack_o,
  // pins and settings
  input wire logic                    external_reset_pin_n,
  input wire logic                    sleep_i,
  input wire cfg_word_pkg::cfg_ctrl_s cfg_ctrl_o
);
  logic [11:0] w_ff;
  logic [2:0]  c_ff;
  wire         tk = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire         bre = cfg_ctrl_o.brownout_reset_en;
  // mirrors of word and control; follow the byte enables as the decoder does
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      {w_ff, c_ff} <= 15'h7ff8;
    else if (tk && wb_we_i && wb_adr_i == cfg_word_pkg::CFG_WORD_ADDR)
    begin
      if (wb_sel_i[0])
        w_ff[7:0] <= wb_dat_i[7:0];
      if (wb_sel_i[1])
        w_ff[11:8] <= wb_dat_i[11:8];
    end
    else if (tk && wb_we_i && wb_adr_i == cfg_word_pkg::CTRL_ADDR && wb_sel_i[0])
      c_ff <= wb_dat_i[2:0];
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_take; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_pin_low; !external_reset_pin_n [*5]; endsequence
  a_ack_pulse: assert property (s_take |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not one cycle after request");
  a_word_read: assert property (s_take ##0 !wb_we_i && wb_adr_i == 16'h2007 |=>
    wb_dat_o == {20'h0_0000, w_ff}) else $error("word read back wrong");
  a_bor_fixed: assert property ($past(rst_n) && $past(w_ff[9]) == $past(w_ff[8]) |->
    bre == $past(w_ff[8])) else $error("brownout fixed mode wrong");
  a_bor_awake: assert property ($past(rst_n) && $past(w_ff[9:8]) == 2'b10 |->
    bre == !($past(c_ff[1]) || $past(sleep_i))) else $error("brownout sleep mode wrong");
  a_bor_soft: assert property ($past(rst_n) && $past(w_ff[9:8]) == 2'b01 |->
    bre == $past(c_ff[0])) else $error("brownout software mode wrong");
  a_pwrup_sel: assert property ($past(rst_n) |->
    cfg_ctrl_o.powerup_timer_en == !$past(w_ff[4])) else $error("powerup timer wrong");
  a_pin_ignored: assert property ($past(rst_n) && !$past(w_ff[5]) |-> cfg_ctrl_o.internal_reset
    && !cfg_ctrl_o.osc_stop && cfg_ctrl_o.chip_reset_req == $past(c_ff[2])) else $error("pin not ignored");
  a_osc_stop: assert property (s_pin_low ##0 $past(w_ff[5]) && $past(w_ff[2]) |->
    cfg_ctrl_o.osc_stop && cfg_ctrl_o.chip_reset_req) else $error("oscillator not stopped");
endmodule
bind config_word_decode config_word_decode_properties config_word_decode_properties_inst (.mclk,
  .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
  .external_reset_pin_n, .sleep_i, .cfg_ctrl_o);

// ==== tb/config_word_decode_bench.sv ====
// self-checking bench for the configuration word decoder
`timescale 1ns/1ps
module config_word_decode_bench;
  logic                    mclk, rst_n, cyc, stb, we, pin_n, sleep, ack;
  logic [15:0]             adr, mask;
  logic [3:0]              sel;
  logic [31:0]             dat, rd, img, q;
  cfg_word_pkg::cfg_ctrl_s ctl;
  int                      err_total, num_checks;
  config_word_decode config_word_decode_inst (.mclk, .rst_n, .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(q),
    .wb_ack_o(ack), .external_reset_pin_n(pin_n), .sleep_i(sleep), .cfg_ctrl_o(ctl));
  cfg_programmer cfg_programmer_inst (.prog_mask(mask), .image(img));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    err_total += int'(g !== e);
    if (g !== e)
      $display("mismatch %s expected %h seen %h", nm, e, g);
  endtask
  task automatic wb(input logic w, input logic [15:0] a, input logic [31:0] d);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    do @(posedge mclk); while (ack !== 1'b1);
    rd = q;
    {cyc, stb} <= 2'b00;
    @(posedge mclk);
  endtask
  // settle covers the pin synchroniser as well as the decode register
  task automatic prog(input logic [15:0] m);
    mask <= m;
    @(posedge mclk);
    wb(1'b1, cfg_word_pkg::CFG_WORD_ADDR, img);
    repeat (6) @(posedge mclk);
  endtask
  task automatic t_reset;
    wb(1'b0, cfg_word_pkg::CFG_WORD_ADDR, 32'h0000_0000);
    chk("word", 32'h0000_0fff, rd);
    wb(1'b0, cfg_word_pkg::STATUS_ADDR, 32'h0000_0000);
    chk("status", 32'h0000_0010, rd);
    wb(1'b0, 16'h2004, 32'h0000_0000);
    chk("unmapped", 32'h0000_0000, rd);
    prog(16'h0000);
    wb(1'b0, cfg_word_pkg::CFG_WORD_ADDR, 32'h0000_0000);
    chk("high bits", 32'h0000_0fff, rd);
  endtask
  task automatic t_bor;
    for (int i = 0; i < 16; i++)
    begin
      prog({6'h00, ~i[3:2], 8'h00});
      sleep <= i[0];
      wb(1'b1, cfg_word_pkg::CTRL_ADDR, 32'(i[1]));
      chk("brownout", 32'(i[3:2] == 2'b11 || (i[3:2] == 2'b10 && !i[0]) || (i[3:2] == 2'b01 && i[1])), 32'(ctl.brownout_reset_en));
    end
    sleep <= 1'b0;
  endtask
  task automatic t_ctrl;
    prog(16'h0100);
    wb(1'b1, cfg_word_pkg::CTRL_ADDR, 32'h0000_0007);
    chk("sleep reg", 32'h0000_0001, 32'(ctl));
    wb(1'b0, cfg_word_pkg::CTRL_ADDR, 32'h0000_0000);
    chk("ctrl", 32'h0000_0007, rd);
    wb(1'b0, cfg_word_pkg::STATUS_ADDR, 32'h0000_0000);
    chk("status", 32'h0000_0001, rd);
    sel <= 4'h2;
    wb(1'b1, cfg_word_pkg::CFG_WORD_ADDR, 32'h0000_fa55);
    sel <= 4'h1;
    wb(1'b1, cfg_word_pkg::CFG_WORD_ADDR, 32'h0000_f000);
    sel <= 4'hf;
    wb(1'b1, 16'h2004, 32'h0000_0000);
    wb(1'b0, cfg_word_pkg::CFG_WORD_ADDR, 32'h0000_0000);
    chk("lanes", 32'h0000_0a00, rd);
    wb(1'b1, cfg_word_pkg::CTRL_ADDR, 32'h0000_0000);
  endtask
  task automatic t_pins;
    prog(16'h0013);
    pin_n <= 1'b0;
    repeat (6) @(posedge mclk);
    chk("pin held", 32'h0000_001b, 32'(ctl));
    prog(16'h0037);
    chk("pin off", 32'h0000_001c, 32'(ctl));
    prog(16'h0014);
    chk("crystal", 32'h0000_0019, 32'(ctl));
    pin_n <= 1'b1;
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial
  begin
    {rst_n, cyc, stb, we, sleep, adr, dat, mask, err_total, num_checks} = '0;
    pin_n = 1'b1;
    sel = 4'hf;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_reset;
    t_bor;
    t_ctrl;
    t_pins;
    wrap_up;
  end
  initial
  begin
    repeat (5000) @(posedge mclk);
    err_total++;
    wrap_up;
  end
endmodule
